// ===== rtl/ch1_shift_data_pkg.sv
// Notes on behaviour
// - Halt mode: no shifting, low power
// - Three-wire full-duplex 8-bit block transfer
// - Most significant bit always sent first
// - Mode register resets to all zeros
// - Enable bit alone writable separately
// - Clock select: external, /16, /8; 01 reserved
// - Enable 0: no shift, counter cleared, flag held
// - Enable 1: shifting, counting, flag may set
// - Shift register write starts a transfer
// - Serialise out, collect in, read in parallel
// - Shift data not cleared by reset
// - Stop after eight bits until next start
// - Start needs enable and idle serial clock
// - Enabling after data write starts nothing
// - Shift on falling, sample on rising edge
// - Eighth bit ends transfer, sets end flag
// - Reset gives halt mode, pins input only
package ch1_shift_data_pkg;
  // Register indices on the plain register port
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] OFS_MODE = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_DATA = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_STATE = 3'h5;
  // Mode register layout
  localparam int MODE_EN_BIT = 7;
  localparam int CKSEL_HI_BIT = 1;
  localparam int CKSEL_LO_BIT = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // Clock select codes
  localparam logic [1:0] CKSEL_EXT = 2'h0;
  localparam logic [1:0] CKSEL_DIV16 = 2'h2;
  localparam logic [1:0] CKSEL_DIV8 = 2'h3;
  // Half-period terminal counts of the divider (8 and 4 clocks)
  localparam logic [2:0] HALF_DIV16 = 3'h7;
  localparam logic [2:0] HALF_DIV8 = 3'h3;
  // Index of the last bit of a block
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Status and state bit positions
  localparam int ST_END_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_SCK_BIT = 2;
  // Transfer state
  typedef enum logic {XFER_IDLE, XFER_RUN} xfer_state_t;
endpackage : ch1_shift_data_pkg

// ===== rtl/ch1_shift_data_channel.sv
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ch1_shift_data_channel
  import ch1_shift_data_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // Interrupt
  output logic IRQ_O,
  // Serial clock pin
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_O,
  // Serial data pins
  input wire logic SI_I,
  output logic SO_O,
  output logic SO_OE_O
);

  // Mode register fields
  logic ch1_enable_bit;
  logic [1:0] clock_select;
  logic next_enable;
  logic [1:0] next_clock_select;

  // Shift data, never reset so contents survive a reset
  logic [7:0] ch1_shift_data;
  logic [7:0] next_shift_data;

  // Transfer control
  xfer_state_t xfer_state;
  xfer_state_t next_xfer_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [2:0] div_cnt;
  logic [2:0] next_div_cnt;
  logic sck_int;
  logic next_sck_int;
  logic so_latch;
  logic next_so_latch;

  // Interrupt status and mask
  logic transfer_end_flag;
  logic next_end_flag;
  logic irq_mask;
  logic next_irq_mask;
  logic next_irq;

  // Read data and pin enables
  logic [7:0] next_rdata;
  logic next_sck_oe;
  logic next_so_oe;

  // Pin synchronisers, three stages each
  logic [2:0] sck_sync;
  logic [2:0] si_sync;
  logic sck_level;
  logic si_level;
  logic next_sck_level;
  logic next_si_level;

  // Decoded strobes and events
  logic wr_mode;
  logic wr_data;
  logic wr_enable;
  logic rd_status;
  logic internal_clk;
  logic ext_clk;
  logic sck_idle;
  logic fall_evt;
  logic rise_evt;
  logic start;

  // Pin sampling: a change counts once stages two and three agree
  always_comb begin
    next_sck_level = sck_level;
    next_si_level = si_level;
    if (sck_sync[1] == sck_sync[2]) begin
      next_sck_level = sck_sync[2];
    end
    if (si_sync[1] == si_sync[2]) begin
      next_si_level = si_sync[2];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      sck_sync <= 3'h7;
      si_sync <= 3'h0;
      sck_level <= 1'b1;
      si_level <= 1'b0;
    end else begin
      sck_sync <= {sck_sync[1:0], SCK_I};
      si_sync <= {si_sync[1:0], SI_I};
      sck_level <= next_sck_level;
      si_level <= next_si_level;
    end
  end

  // Address decode; unmapped addresses write nothing
  assign wr_mode = WR_I && (ADDR_I == OFS_MODE);
  assign wr_data = WR_I && (ADDR_I == OFS_DATA);
  assign wr_enable = WR_I && (ADDR_I == OFS_ENABLE);
  assign rd_status = RD_I && (ADDR_I == OFS_IRQ_STATUS);

  // Clock source; reserved code 01 gives no clock at all
  assign internal_clk = (clock_select == CKSEL_DIV16) || (clock_select == CKSEL_DIV8);
  assign ext_clk = (clock_select == CKSEL_EXT);

  // Terminal count of the divider for the selected rate
  function automatic logic [2:0] half_count(input logic [1:0] sel);
    half_count = (sel == CKSEL_DIV8) ? HALF_DIV8 : HALF_DIV16;
  endfunction : half_count

  // Clock edges: divider toggles, or filtered pin edges
  // edge selection
  assign fall_evt = internal_clk ? (div_cnt == half_count(clock_select)) && sck_int
                  : ext_clk && sck_level && !next_sck_level;
  assign rise_evt = internal_clk ? (div_cnt == half_count(clock_select)) && !sck_int
                  : ext_clk && !sck_level && next_sck_level;

  assign sck_idle = (xfer_state == XFER_IDLE) && (internal_clk || sck_level);
  assign start = wr_data && ch1_enable_bit && sck_idle;

  // Mode register next values
  always_comb begin
    next_enable = ch1_enable_bit;
    next_clock_select = clock_select;
    if (wr_mode) begin
      next_enable = WDATA_I[MODE_EN_BIT];
      next_clock_select = {WDATA_I[CKSEL_HI_BIT], WDATA_I[CKSEL_LO_BIT]};
    end else if (wr_enable) begin
      next_enable = WDATA_I[MODE_EN_BIT];
    end
  end

  // Transfer engine next values
  always_comb begin
    next_xfer_state = xfer_state;
    next_bit_cnt = bit_cnt;
    next_div_cnt = div_cnt;
    next_sck_int = sck_int;
    next_so_latch = so_latch;
    next_shift_data = ch1_shift_data;
    next_end_flag = transfer_end_flag;
    case (xfer_state)
      XFER_IDLE: begin
        next_div_cnt = 3'h0;
        next_sck_int = 1'b1;
        if (wr_data && !ch1_enable_bit) begin
          next_shift_data = WDATA_I;
        end else if (start) begin
          next_shift_data = WDATA_I;
          next_bit_cnt = 3'h0;
          next_xfer_state = XFER_RUN;
        end else if (wr_data) begin
          // Clock low on the pin: keep the data, wait for a new write
          next_shift_data = WDATA_I;
        end
      end
      XFER_RUN: begin
        if (internal_clk) begin
          next_div_cnt = 3'(div_cnt + 3'h1);
          if (fall_evt || rise_evt) begin
            next_div_cnt = 3'h0;
            next_sck_int = !sck_int;
          end
        end
        if (fall_evt) begin
          next_so_latch = ch1_shift_data[7];
        end
        if (rise_evt) begin
          // Settled level taken one clock early: at /8 the pin filter
          // lags almost a full half period behind the peer's change
          next_shift_data = {ch1_shift_data[6:0], next_si_level};
          next_bit_cnt = 3'(bit_cnt + 3'h1);
          if (bit_cnt == LAST_BIT) begin
            next_xfer_state = XFER_IDLE;
            next_bit_cnt = 3'h0;
          end
        end
      end
      default: begin
        next_xfer_state = XFER_IDLE;
      end
    endcase
    // Read of status clears the flag; a new end event wins
    if (rd_status) begin
      next_end_flag = 1'b0;
    end
    if ((xfer_state == XFER_RUN) && rise_evt && (bit_cnt == LAST_BIT)) begin
      next_end_flag = 1'b1;
    end
    if (!ch1_enable_bit) begin
      next_xfer_state = XFER_IDLE;
      next_bit_cnt = 3'h0;
      next_div_cnt = 3'h0;
      next_sck_int = 1'b1;
      next_end_flag = rd_status ? 1'b0 : transfer_end_flag;
    end
  end

  // Interrupt mask, read data, pin drive next values
  always_comb begin
    next_irq_mask = irq_mask;
    if (WR_I && (ADDR_I == OFS_IRQ_MASK)) begin
      next_irq_mask = WDATA_I[ST_END_BIT];
    end
    next_irq = next_end_flag && next_irq_mask;
    next_rdata = 8'h00;
    if (RD_I) begin
      case (ADDR_I)
        OFS_DATA: next_rdata = ch1_shift_data;
        OFS_IRQ_STATUS: next_rdata[ST_END_BIT] = transfer_end_flag;
        OFS_IRQ_MASK: next_rdata[ST_END_BIT] = irq_mask;
        OFS_STATE: begin
          next_rdata[ST_END_BIT] = transfer_end_flag;
          next_rdata[ST_BUSY_BIT] = (xfer_state == XFER_RUN);
          next_rdata[ST_SCK_BIT] = internal_clk ? sck_int : sck_level;
        end
        // Mode register is write-only and reads zero
        default: next_rdata = 8'h00;
      endcase
    end
    next_sck_oe = next_enable && (next_clock_select == CKSEL_DIV16 || next_clock_select == CKSEL_DIV8);
    next_so_oe = next_enable;
  end

  // Registers; shift data has no reset on purpose
  always_ff @(posedge MCLK_I) begin
    ch1_shift_data <= next_shift_data;
    if (!RSTN_I) begin
      ch1_enable_bit <= MODE_RESET[MODE_EN_BIT];
      clock_select <= {MODE_RESET[CKSEL_HI_BIT], MODE_RESET[CKSEL_LO_BIT]};
      xfer_state <= XFER_IDLE;
      bit_cnt <= 3'h0;
      div_cnt <= 3'h0;
      sck_int <= 1'b1;
      so_latch <= 1'b1;
      transfer_end_flag <= 1'b0;
      irq_mask <= 1'b0;
      IRQ_O <= 1'b0;
      RDATA_O <= 8'h00;
      SCK_O <= 1'b1;
      SCK_OE_O <= 1'b0;
      SO_O <= 1'b1;
      SO_OE_O <= 1'b0;
    end else begin
      ch1_enable_bit <= next_enable;
      clock_select <= next_clock_select;
      xfer_state <= next_xfer_state;
      bit_cnt <= next_bit_cnt;
      div_cnt <= next_div_cnt;
      sck_int <= next_sck_int;
      so_latch <= next_so_latch;
      transfer_end_flag <= next_end_flag;
      irq_mask <= next_irq_mask;
      IRQ_O <= next_irq;
      RDATA_O <= next_rdata;
      SCK_O <= next_sck_int;
      SCK_OE_O <= next_sck_oe;
      SO_O <= next_so_latch;
      SO_OE_O <= next_so_oe;
    end
  end

  // Checks
  // reset clears mode
  reset_mode_a: assert property (@(posedge MCLK_I)
    !RSTN_I |=> !ch1_enable_bit && clock_select == CKSEL_EXT && !SO_OE_O && !SCK_OE_O)
    else $error("mode not cleared by reset");

  halt_idle_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    !ch1_enable_bit |=> xfer_state == XFER_IDLE && bit_cnt == 3'h0 && div_cnt == 3'h0)
    else $error("engine active while halted");

  start_xfer_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    wr_data && ch1_enable_bit && xfer_state == XFER_IDLE && (internal_clk || sck_level) && !wr_mode && !wr_enable
    |=> xfer_state == XFER_RUN && ch1_shift_data == $past(WDATA_I))
    else $error("write did not start transfer");

  no_late_start_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    xfer_state == XFER_IDLE && !wr_data ##1 !wr_data |=> xfer_state == XFER_IDLE)
    else $error("transfer started without write");

  no_restart_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    xfer_state == XFER_RUN && wr_data && ch1_enable_bit && !rise_evt |=> bit_cnt == $past(bit_cnt))
    else $error("busy write disturbed bit count");

  eighth_bit_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    xfer_state == XFER_RUN && ch1_enable_bit && rise_evt && bit_cnt == LAST_BIT
    |=> transfer_end_flag && xfer_state == XFER_IDLE ##1 IRQ_O == (transfer_end_flag && irq_mask))
    else $error("eighth bit did not end transfer");

  msb_out_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    xfer_state == XFER_RUN && ch1_enable_bit && fall_evt |=> so_latch == $past(ch1_shift_data[7]) ##1 SO_O == $past(so_latch))
    else $error("output bit not the top bit");

  rx_sample_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    xfer_state == XFER_RUN && ch1_enable_bit && rise_evt |=> ch1_shift_data[0] == $past(next_si_level))
    else $error("input bit not sampled");

  halt_hold_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    !ch1_enable_bit && !wr_data |=> ch1_shift_data == $past(ch1_shift_data))
    else $error("data shifted while halted");
  link_drive_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    xfer_state == XFER_RUN && ch1_enable_bit && internal_clk |-> SCK_OE_O && SO_OE_O)
    else $error("link pins not driven in transfer");
  enable_only_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    wr_enable |=> clock_select == $past(clock_select) && ch1_enable_bit == $past(WDATA_I[MODE_EN_BIT]))
    else $error("enable write touched other fields");
  reserved_quiet_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    !internal_clk && !ext_clk |-> !fall_evt && !rise_evt)
    else $error("reserved clock code produced edges");
  sck_dir_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    SCK_OE_O == (ch1_enable_bit && internal_clk))
    else $error("clock pin direction wrong");
  end_held_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    !ch1_enable_bit && !rd_status |=> transfer_end_flag == $past(transfer_end_flag))
    else $error("end flag changed while halted");
  so_enable_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    SO_OE_O == ch1_enable_bit)
    else $error("data pin enable wrong");
  keep_data_a: assert property (@(posedge MCLK_I)
    !RSTN_I && xfer_state == XFER_IDLE && !wr_data |=> ch1_shift_data == $past(ch1_shift_data))
    else $error("reset disturbed idle data");
  stay_idle_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    xfer_state == XFER_IDLE && !start |=> xfer_state == XFER_IDLE)
    else $error("left idle without a start");
  edge_only_a: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    xfer_state == XFER_RUN && ch1_enable_bit && !rise_evt |=> ch1_shift_data == $past(ch1_shift_data))
    else $error("data changed off a rising edge");
  reset_pins_a: assert property (@(posedge MCLK_I)
    !RSTN_I |=> SO_O && SCK_O && !IRQ_O && RDATA_O == 8'h00)
    else $error("pins not at reset levels");

endmodule : ch1_shift_data_channel
`default_nettype wire

// ===== sim/ch1_shift_data_peer.sv
`timescale 1ns/10ps
`default_nettype none
module ch1_shift_data_peer (
  // Clock used to pace external pulses
  input wire logic clk_i,
  // Serial lines at the pins
  input wire logic sck_i,
  input wire logic so_i,
  output logic si_o,
  output logic sck_o
);
  logic [7:0] tx; // Bits still to send
  logic [7:0] rx; // Bits collected from the device
  initial begin
    si_o = 1'b0;
    sck_o = 1'b1;
    tx = 8'h00;
    rx = 8'h00;
  end
  // Next bit after each falling edge; refill with a changing pattern
  always @(negedge sck_i) begin
    si_o <= tx[7];
    tx <= {tx[6:0], ~tx[0]};
  end
  // Collect device data on the rising edge
  always @(posedge sck_i) begin
    rx <= {rx[6:0], so_i};
  end
  // Arm a byte; line flips so a stale level is never trusted
  task load(input logic [7:0] b);
    tx = b;
    si_o = ~si_o;
  endtask : load
  // Eight slow pulses; clock stands high outside the frame
  task ext8();
    repeat (8) begin
      repeat (10) @(posedge clk_i);
      sck_o <= 1'b0;
      repeat (10) @(posedge clk_i);
      sck_o <= 1'b1;
    end
  endtask : ext8
endmodule : ch1_shift_data_peer
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ch1_shift_data_pkg::*;
  logic clk = 1'b0; // System clock
  logic rst_n = 1'b0; // Reset, active low
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic irq, sck_o, sck_oe, so, so_oe, si, ext_sck;
  logic [7:0] d;
  int bad_count = 0;
  int comparisons = 0;
  // Rows: mode, byte sent, byte the peer returns
  logic [23:0] rows [4] = '{24'h82_A53C, 24'h83_01FE, 24'h80_807F, 24'h83_FF00};
  wire sck_w = sck_oe ? sck_o : ext_sck; // Level on the clock wire
  always #10 clk = ~clk;
  ch1_shift_data_channel dut (.MCLK_I(clk), .RSTN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_O(sck_oe),
    .SI_I(si), .SO_O(so), .SO_OE_O(so_oe));
  ch1_shift_data_peer peer (.clk_i(clk), .sck_i(sck_w), .so_i(so), .si_o(si), .sck_o(ext_sck));
  // Compare one byte or flag
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Data stand only in the cycle after the strobe
  task rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  // Bounded wait for the interrupt
  task wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n >= 600) begin
      bad_count++;
      $display("ERROR %0t interrupt never came", $time);
      stop_test();
    end
  endtask : wait_irq
  task stop_test();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    // Reset levels of pins
    chk({so_oe, sck_oe, so}, 8'h01);
    rd_reg(OFS_STATE, d);
    chk(d, 8'h04);
    rd_reg(OFS_MODE, d);
    chk(d, 8'h00);
    rd_reg(3'h7, d);
    chk(d, 8'h00);
    // Halted: data write starts nothing
    wr_reg(OFS_DATA, 8'h96);
    repeat (20) @(posedge clk);
    rd_reg(OFS_STATE, d);
    chk(d, 8'h04);
    rd_reg(OFS_DATA, d);
    chk(d, 8'h96);
    // Enabling afterwards starts nothing either
    wr_reg(OFS_ENABLE, 8'h80);
    repeat (40) @(posedge clk);
    rd_reg(OFS_STATE, d);
    chk(d, 8'h04);
    chk({7'h00, so_oe}, 8'h01);
    wr_reg(OFS_IRQ_MASK, 8'h01);
    $display("test halt done");
    foreach (rows[i]) begin
      // Bits 2 to 6 written as zero
      wr_reg(OFS_MODE, rows[i][23:16]);
      peer.load(rows[i][7:0]);
      wr_reg(OFS_DATA, rows[i][15:8]);
      if (rows[i][17:16] == CKSEL_EXT) peer.ext8();
      wait_irq();
      chk(peer.rx, rows[i][15:8]);
      rd_reg(OFS_DATA, d);
      chk(d, rows[i][7:0]);
      rd_reg(OFS_IRQ_STATUS, d);
      chk(d, 8'h01);
      @(posedge clk);
      #1 chk({7'h00, irq}, 8'h00);
      $display("test row %0d done", i);
    end
    // Write while busy is ignored; masked interrupt stays low
    wr_reg(OFS_IRQ_MASK, 8'h00);
    peer.load(8'h5A);
    wr_reg(OFS_DATA, 8'hC3);
    repeat (20) @(posedge clk);
    wr_reg(OFS_DATA, 8'h00);
    repeat (120) @(posedge clk);
    chk(peer.rx, 8'hC3);
    chk({7'h00, irq}, 8'h00);
    wr_reg(OFS_IRQ_MASK, 8'h01);
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    rd_reg(OFS_DATA, d);
    chk(d, 8'h5A);
    rd_reg(OFS_IRQ_STATUS, d);
    chk(d, 8'h01);
    $display("test busy done");
    // Reserved code never clocks
    wr_reg(OFS_MODE, 8'h81);
    wr_reg(OFS_DATA, 8'h11);
    repeat (300) @(posedge clk);
    rd_reg(OFS_IRQ_STATUS, d);
    chk(d, 8'h00);
    wr_reg(OFS_MODE, 8'h00);
    repeat (4) @(posedge clk);
    rd_reg(OFS_STATE, d);
    chk(d, 8'h04);
    $display("test reserved done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
